// ==== logic/rdcc_top.sv ====
// Purpose: Channel control for an eight-channel relay and LED driver.
// Assumes: 20 MHz clock; serial clock of at most 5 MHz; APB master in the clock domain.
// Notes:   Analog pins (supply present, overload, over-temperature, monitor) arrive asynchronous.
// Operation
// - Control and diagnosis travel in 16-bit frames.
// - Daisy chain, also with 8-bit devices.
// - Each input pin drives its channel directly.
// - Input mapping routes inputs to any channels.
// - Limp home routes inputs to channels 2, 3.
// - Limp home switching needs idle low and no digital supply.
// - Overload latches channel off until re-enabled.
// - Limp home restarts overloaded channels 2, 3 with input high after delay.
// - Probe current enable and output status bits.
// - Serial access only with digital supply; state kept.
// - Diagnostics latched until read out.
// - Over-temperature latches channel off.
// - Serial output released while chip select high.
// - Idle pin high selects idle; undriven reads low.
// - First input to channel 2, second to 3.
`include "rdcc_defs.svh"
module rdcc_top
	import rdcc_pkg::*;
#(
	parameter int CHANNELS       = 8,
	parameter int RESTART_CYCLES = `RDCC_LH_RESTART_CYC
) (
	// Clock, reset, clock enable
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                en,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Serial link pins
	input  wire logic                sclk,
	input  wire logic                sdi,
	input  wire logic                chip_select_low_n,
	output logic                     sdo,
	output logic                     sdoOe,
	// Direct pins and supply
	input  wire logic                direct_input_a,
	input  wire logic                direct_input_b,
	input  wire logic                idlePin,
	input  wire logic                digitalSupplyOk,
	// Power stage feedback
	input  wire logic [CHANNELS-1:0] overload_trip_current,
	input  wire logic [CHANNELS-1:0] overTemp,
	input  wire logic [CHANNELS-1:0] output_status_monitor_bits,
	// Power stage control
	output logic      [CHANNELS-1:0] chanOn,
	output logic      [CHANNELS-1:0] open_load_probe_current,
	output logic                     idleMode,
	output logic                     limpHome,
	output logic                     irq
);
	localparam int SYN = 5 + 3 * CHANNELS;
	localparam int CW  = $clog2(RESTART_CYCLES + 1);

	// Synchronised pins.
	logic [SYN-1:0]      synIn;
	logic [SYN-1:0]      synOut;
	rdcc_link_t          linkSync;
	logic                inA;
	logic                inB;
	logic                idleSync;
	logic                vddSync;
	logic [CHANNELS-1:0] ovlSync;
	logic [CHANNELS-1:0] otSync;
	logic [CHANNELS-1:0] osmSync;

	assign synIn = {output_status_monitor_bits, overTemp, overload_trip_current,
		digitalSupplyOk, idlePin, direct_input_b, direct_input_a, sdi};

	rdcc_sync #(.WIDTH(SYN)) u_pinSync (
		.clock   (clock),
		.rst_n   (rst_n),
		.en      (en),
		.asyncIn (synIn),
		.syncOut (synOut)
	);

	// Chip select and serial clock are synchronised apart so chip select can reset high.
	logic [1:0] csStage_q;
	logic [1:0] sclkStage_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			csStage_q   <= 2'b11;
			sclkStage_q <= 2'b00;
		end else if (en) begin
			csStage_q   <= {csStage_q[0], chip_select_low_n};
			sclkStage_q <= {sclkStage_q[0], sclk};
		end
	end

	assign linkSync.sdi   = synOut[0];
	assign linkSync.csLow = csStage_q[1];
	assign linkSync.sclk  = sclkStage_q[1];
	assign inA            = synOut[1];
	assign inB            = synOut[2];
	assign idleSync       = synOut[3];
	assign vddSync        = synOut[4];
	assign ovlSync        = synOut[5 +: CHANNELS];
	assign otSync         = synOut[5 + CHANNELS +: CHANNELS];
	assign osmSync        = synOut[5 + 2 * CHANNELS +: CHANNELS];

	// Control registers.
	logic [CHANNELS-1:0]      ctrl_q;
	logic [CHANNELS-1:0]      mapA_q;
	logic [CHANNELS-1:0]      mapB_q;
	logic [CHANNELS-1:0]      ovlLatch_q;
	logic [CHANNELS-1:0]      otLatch_q;
	logic [CHANNELS-1:0]      diagOvl_q;
	logic [CHANNELS-1:0]      diagOt_q;
	logic [`RDCC_IRQ_BITS-1:0] irqStat_q;
	logic [`RDCC_IRQ_BITS-1:0] irqMask_q;
	logic [15:0]              txWord_q;
	rdcc_lh_state_t           lhState_q;
	logic [CW-1:0]            lhCount_q;

	// Serial engine.
	rdcc_frame_t rxFrame;
	logic        rxValid;
	logic        sdoRaw;

	rdcc_spi_link u_link (
		.clock   (clock),
		.rst_n   (rst_n),
		.en      (en),
		.link    (linkSync),
		.txWord  (txWord_q),
		.rxFrame (rxFrame),
		.rxValid (rxValid),
		.sdo     (sdoRaw)
	);

	// Frames are only taken while the digital supply is present.
	wire spiTake = rxValid & vddSync;
	wire spiWr   = spiTake & rxFrame.wr;

	function automatic logic hit(input logic [2:0] idx, input logic [2:0] want);
		return spiWr && (idx == want);
	endfunction

	// APB decode: a write or read takes effect at the edge that sees pready high.
	wire apbDone = psel & penable & pready;
	wire apbWr   = apbDone & pwrite;
	wire apbRd   = apbDone & ~pwrite;
	wire mapped  = (paddr == `RDCC_OFF_CTRL) || (paddr == `RDCC_OFF_MAPA) ||
		(paddr == `RDCC_OFF_MAPB) || (paddr == `RDCC_OFF_RESTART) ||
		(paddr == `RDCC_OFF_PROBE) || (paddr == `RDCC_OFF_DIAG) ||
		(paddr == `RDCC_OFF_IRQSTAT) || (paddr == `RDCC_OFF_IRQMASK) ||
		(paddr == `RDCC_OFF_CHAN);

	function automatic logic apbHit(input logic [7:0] a, input logic [7:0] want);
		return (a == want);
	endfunction

	wire [CHANNELS-1:0] wData = pwdata[CHANNELS-1:0];
	wire [CHANNELS-1:0] sData = rxFrame.data[CHANNELS-1:0];
	wire ctrlWr  = hit(rxFrame.idx, `RDCC_SPI_CTRL) | (apbWr & apbHit(paddr, `RDCC_OFF_CTRL));
	wire mapAWr  = hit(rxFrame.idx, `RDCC_SPI_MAPA) | (apbWr & apbHit(paddr, `RDCC_OFF_MAPA));
	wire mapBWr  = hit(rxFrame.idx, `RDCC_SPI_MAPB) | (apbWr & apbHit(paddr, `RDCC_OFF_MAPB));
	wire probeWr = hit(rxFrame.idx, `RDCC_SPI_PROBE) | (apbWr & apbHit(paddr, `RDCC_OFF_PROBE));
	wire [CHANNELS-1:0] newVal = spiWr ? sData : wData;

	// Restart command: ones release the latched-off channels.
	wire [CHANNELS-1:0] restartSpi = hit(rxFrame.idx, `RDCC_SPI_RESTART) ? sData : '0;
	wire [CHANNELS-1:0] restartApb =
		(apbWr & apbHit(paddr, `RDCC_OFF_RESTART)) ? wData : '0;

	// Diagnostics clear on read from either side.
	wire diagRead = (apbRd & apbHit(paddr, `RDCC_OFF_DIAG)) |
		(spiTake & ~rxFrame.wr & (rxFrame.idx == `RDCC_SPI_DIAG));

	// Limp home: idle pin low and no digital supply.
	wire lhMode = ~idleSync & ~vddSync;

	// Channel demand.
	logic [CHANNELS-1:0] demand;
	always_comb begin
		demand = ctrl_q | (mapA_q & {CHANNELS{inA}}) | (mapB_q & {CHANNELS{inB}});
		if (lhMode) begin
			demand    = ctrl_q;
			demand[2] = inA;
			demand[3] = inB;
		end
	end

	wire [CHANNELS-1:0] latched = ovlLatch_q | otLatch_q;
	wire [CHANNELS-1:0] ovlTrip = ovlSync & chanOn;
	wire [CHANNELS-1:0] otTrip  = otSync;

	// Limp-home restart of channels 2 and 3 whose input is high.
	wire lhDone = (lhState_q == LH_WAIT) && (lhCount_q == CW'(RESTART_CYCLES - 1));
	logic [CHANNELS-1:0] lhRestart;
	always_comb begin
		lhRestart    = '0;
		lhRestart[2] = lhDone & inA;
		lhRestart[3] = lhDone & inB;
	end
	wire lhPending = lhMode & ((ovlLatch_q[2] & inA) | (ovlLatch_q[3] & inB));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lhState_q <= LH_IDLE;
			lhCount_q <= '0;
		end else if (en) begin
			case (lhState_q)
				LH_IDLE: begin
					lhCount_q <= '0;
					if (lhPending) begin
						lhState_q <= LH_WAIT;
					end
				end
				LH_WAIT: begin
					lhCount_q <= lhCount_q + CW'(1);
					if (!lhPending || lhDone) begin
						lhState_q <= LH_IDLE;
					end
				end
				default: begin
					lhState_q <= LH_IDLE;
				end
			endcase
		end
	end

	// Configuration; serial writes and APB writes share the registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q                  <= CHANNELS'(`RDCC_RST_CTRL);
			mapA_q                  <= CHANNELS'(`RDCC_RST_MAPA);
			mapB_q                  <= CHANNELS'(`RDCC_RST_MAPB);
			open_load_probe_current <= CHANNELS'(`RDCC_RST_PROBE);
		end else if (en) begin
			if (ctrlWr) begin
				ctrl_q <= newVal;
			end
			if (mapAWr) begin
				mapA_q <= newVal;
			end
			if (mapBWr) begin
				mapB_q <= newVal;
			end
			if (probeWr) begin
				open_load_probe_current <= newVal;
			end
		end
	end

	// Protection latches: a trip in the same cycle as a restart wins.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ovlLatch_q <= '0;
			otLatch_q  <= '0;
		end else if (en) begin
			ovlLatch_q <= (ovlLatch_q & ~(restartSpi | restartApb | lhRestart)) | ovlTrip;
			otLatch_q  <= (otLatch_q & ~(restartSpi | restartApb)) | otTrip;
		end
	end

	// Latched diagnosis; an event in the read cycle is kept.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			diagOvl_q <= '0;
			diagOt_q  <= '0;
		end else if (en) begin
			diagOvl_q <= (diagRead ? '0 : diagOvl_q) | ovlTrip;
			diagOt_q  <= (diagRead ? '0 : diagOt_q) | otTrip;
		end
	end

	// Outputs to the power stage.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chanOn   <= '0;
			idleMode <= 1'b0;
			limpHome <= 1'b0;
		end else if (en) begin
			chanOn   <= demand & ~latched & ~(ovlTrip | otTrip);
			idleMode <= idleSync;
			limpHome <= lhMode;
		end
	end

	// Serial answer for the next frame: addressed register on a read, else diagnosis.
	logic [7:0] spiRead;
	always_comb begin
		case (rxFrame.idx)
			`RDCC_SPI_CTRL:  spiRead = 8'(ctrl_q);
			`RDCC_SPI_MAPA:  spiRead = 8'(mapA_q);
			`RDCC_SPI_MAPB:  spiRead = 8'(mapB_q);
			`RDCC_SPI_PROBE: spiRead = 8'(open_load_probe_current);
			`RDCC_SPI_DIAG:  spiRead = 8'(diagOvl_q | diagOt_q);
			default:         spiRead = 8'(osmSync);
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txWord_q <= 16'h0000;
			sdo      <= 1'b0;
			sdoOe    <= 1'b0;
		end else if (en) begin
			if (spiTake) begin
				txWord_q <= rxFrame.wr ? {8'(diagOt_q), 8'(diagOvl_q)} :
					{1'b0, rxFrame.idx, 4'h0, spiRead};
			end
			sdo   <= sdoRaw;
			sdoOe <= ~linkSync.csLow & vddSync;
		end
	end

	// Interrupt status, write one to clear; a new event wins over the clear.
	wire [`RDCC_IRQ_BITS-1:0] irqEvt = {spiTake, |otTrip, |ovlTrip};
	wire [`RDCC_IRQ_BITS-1:0] irqClr =
		(apbWr & apbHit(paddr, `RDCC_OFF_IRQSTAT)) ? pwdata[`RDCC_IRQ_BITS-1:0] : '0;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_q <= '0;
			irqMask_q <= '0;
			irq       <= 1'b0;
		end else if (en) begin
			irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
			if (apbWr && apbHit(paddr, `RDCC_OFF_IRQMASK)) begin
				irqMask_q <= pwdata[`RDCC_IRQ_BITS-1:0];
			end
			irq <= |(irqStat_q & irqMask_q);
		end
	end

	// APB read mux, sampled in the setup cycle so the access phase ends in one cycle.
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		case (paddr)
			`RDCC_OFF_CTRL:    rdMux[CHANNELS-1:0] = ctrl_q;
			`RDCC_OFF_MAPA:    rdMux[CHANNELS-1:0] = mapA_q;
			`RDCC_OFF_MAPB:    rdMux[CHANNELS-1:0] = mapB_q;
			`RDCC_OFF_PROBE:   rdMux[CHANNELS-1:0] = open_load_probe_current;
			`RDCC_OFF_DIAG: begin
				rdMux[`RDCC_DIAG_OVL_LSB +: CHANNELS] = diagOvl_q;
				rdMux[`RDCC_DIAG_OT_LSB +: CHANNELS]  = diagOt_q;
				rdMux[`RDCC_DIAG_OSM_LSB +: CHANNELS] = osmSync;
			end
			`RDCC_OFF_IRQSTAT: rdMux[`RDCC_IRQ_BITS-1:0] = irqStat_q;
			`RDCC_OFF_IRQMASK: rdMux[`RDCC_IRQ_BITS-1:0] = irqMask_q;
			`RDCC_OFF_CHAN:    rdMux[CHANNELS-1:0] = chanOn;
			default:           rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (en) begin
			if (psel && !penable) begin
				prdata  <= pwrite ? 32'h0000_0000 : rdMux;
				pready  <= 1'b1;
				pslverr <= ~mapped;
			end else if (apbDone) begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end
endmodule

// ==== include/rdcc_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the relay channel control.
// Assumes: 20 MHz system clock, APB with 32-bit data, 16-bit serial frames.
// Notes:   Definitions only.
`ifndef RDCC_DEFS_SVH
`define RDCC_DEFS_SVH

`define RDCC_CLK_MHZ          20
`define RDCC_LH_RESTART_US    1000
`define RDCC_LH_RESTART_CYC   (`RDCC_LH_RESTART_US * `RDCC_CLK_MHZ)
`define RDCC_FRAME_BITS       16

`define RDCC_OFF_CTRL         8'h00
`define RDCC_OFF_MAPA         8'h04
`define RDCC_OFF_MAPB         8'h08
`define RDCC_OFF_RESTART      8'h0C
`define RDCC_OFF_PROBE        8'h10
`define RDCC_OFF_DIAG         8'h14
`define RDCC_OFF_IRQSTAT      8'h18
`define RDCC_OFF_IRQMASK      8'h1C
`define RDCC_OFF_CHAN         8'h20

`define RDCC_SPI_CTRL         3'h0
`define RDCC_SPI_MAPA         3'h1
`define RDCC_SPI_MAPB         3'h2
`define RDCC_SPI_RESTART      3'h3
`define RDCC_SPI_PROBE        3'h4
`define RDCC_SPI_DIAG         3'h5

`define RDCC_RST_CTRL         8'h00
`define RDCC_RST_MAPA         8'h04
`define RDCC_RST_MAPB         8'h08
`define RDCC_RST_PROBE        8'h00

`define RDCC_IRQ_OVERLOAD     0
`define RDCC_IRQ_OVERTEMP     1
`define RDCC_IRQ_FRAME        2
`define RDCC_IRQ_BITS         3

`define RDCC_DIAG_OVL_LSB     0
`define RDCC_DIAG_OT_LSB      8
`define RDCC_DIAG_OSM_LSB     16

`endif

// ==== include/rdcc_pkg.sv ====
// Purpose: Types shared by the relay channel control files.
// Assumes: Nothing beyond the defs header.
// Notes:   Serial frame layout: write flag, register index, reserved, data byte.
package rdcc_pkg;

	typedef struct packed {
		logic       wr;
		logic [2:0] idx;
		logic [3:0] rsvd;
		logic [7:0] data;
	} rdcc_frame_t;

	typedef struct packed {
		logic       sclk;
		logic       sdi;
		logic       csLow;
	} rdcc_link_t;

	typedef enum logic [0:0] {
		LH_IDLE,
		LH_WAIT
	} rdcc_lh_state_t;

endpackage

// ==== logic/rdcc_sync.sv ====
// Purpose: Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs are levels from outside the clock domain.
// Notes:   The first stage is read only by the second.
module rdcc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             en,
	// Data
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_q;

	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					stage1_q[i] <= 1'b0;
					syncOut[i]  <= 1'b0;
				end else if (en) begin
					stage1_q[i] <= asyncIn[i];
					syncOut[i]  <= stage1_q[i];
				end
			end
		end
	endgenerate
endmodule

// ==== logic/rdcc_spi_link.sv ====
// Purpose: 16-bit serial slave engine, oversampled by the system clock.
// Assumes: Link signals arrive already synchronised; serial clock idles low, mode 0.
// Notes:   Data shifts through, so extra bits of a daisy chain pass to the next device.
`include "rdcc_defs.svh"
module rdcc_spi_link
	import rdcc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        en,
	// Synchronised link
	input  rdcc_link_t       link,
	// Frame exchange
	input  wire logic [15:0] txWord,
	output rdcc_frame_t      rxFrame,
	output logic             rxValid,
	output logic             sdo
);
	logic [15:0] shift_q;
	logic [4:0]  count_q;
	logic        sclkPrev_q;
	logic        csPrev_q;

	wire sclkRise = link.sclk & ~sclkPrev_q;
	wire sclkFall = ~link.sclk & sclkPrev_q;
	wire csFall   = ~link.csLow & csPrev_q;
	wire csRise   = link.csLow & ~csPrev_q;
	wire active   = ~link.csLow;
	wire full     = (count_q >= 5'(`RDCC_FRAME_BITS));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_q    <= 16'h0000;
			count_q    <= 5'h00;
			sclkPrev_q <= 1'b0;
			csPrev_q   <= 1'b1;
			rxFrame    <= '0;
			rxValid    <= 1'b0;
			sdo        <= 1'b0;
		end else if (en) begin
			sclkPrev_q <= link.sclk;
			csPrev_q   <= link.csLow;
			rxValid    <= 1'b0;
			if (csFall) begin
				shift_q <= txWord;
				count_q <= 5'h00;
				sdo     <= txWord[15];
			end else if (active && sclkRise) begin
				shift_q <= {shift_q[14:0], link.sdi};
				if (!full) begin
					count_q <= count_q + 5'h01;
				end
			end else if (active && sclkFall) begin
				sdo <= shift_q[15];
			end
			// Frames shorter than 16 bits are dropped; longer ones keep the last 16 bits.
			if (csRise && full) begin
				rxFrame <= rdcc_frame_t'(shift_q);
				rxValid <= 1'b1;
			end
		end
	end
endmodule

// ==== bench/rdcc_top_props.sv ====
// Purpose: Concurrent checks on the ports of the relay channel control.
// Assumes: Pins reach the outputs through two sync stages and one output flop.
// Notes:   Five steady clocks cover that latency with one cycle to spare.
module rdcc_top_props #(
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic                clock,
	input wire logic                rst_n,
	// Bus handshake
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready,
	// Pins
	input wire logic                chip_select_low_n,
	input wire logic                sdoOe,
	input wire logic                direct_input_a,
	input wire logic                direct_input_b,
	input wire logic                idlePin,
	input wire logic                digitalSupplyOk,
	input wire logic [CHANNELS-1:0] overload_trip_current,
	input wire logic [CHANNELS-1:0] overTemp,
	// Outputs
	input wire logic [CHANNELS-1:0] chanOn,
	input wire logic                idleMode,
	input wire logic                limpHome
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	property p_apb_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("bus access not answered");
	property p_sdo_release;
		chip_select_low_n [*5] |-> !sdoOe;
	endproperty
	a_sdo_release: assert property (p_sdo_release) else $error("data out driven");
	property p_no_supply;
		!digitalSupplyOk [*5] |-> !sdoOe;
	endproperty
	a_no_supply: assert property (p_no_supply) else $error("link live without supply");
	property p_overload;
		$stable(overload_trip_current) [*5] |-> (chanOn & overload_trip_current) == '0;
	endproperty
	a_overload: assert property (p_overload) else $error("overloaded channel on");
	property p_overtemp;
		$stable(overTemp) [*5] |-> (chanOn & overTemp) == '0;
	endproperty
	a_overtemp: assert property (p_overtemp) else $error("hot channel on");
	property p_limp_a;
		(limpHome && !direct_input_a) [*5] |-> !chanOn[2];
	endproperty
	a_limp_a: assert property (p_limp_a) else $error("channel 2 not following input");
	property p_limp_b;
		(limpHome && !direct_input_b) [*5] |-> !chanOn[3];
	endproperty
	a_limp_b: assert property (p_limp_b) else $error("channel 3 not following input");
	property p_limp_entry;
		$stable({idlePin, digitalSupplyOk}) [*5] |-> limpHome == (!idlePin && !digitalSupplyOk);
	endproperty
	a_limp_entry: assert property (p_limp_entry) else $error("limp home state wrong");
	property p_idle;
		$stable(idlePin) [*5] |-> idleMode == idlePin;
	endproperty
	a_idle: assert property (p_idle) else $error("idle mode not following pin");
endmodule

bind rdcc_top rdcc_top_props #(.CHANNELS(CHANNELS)) props (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.chip_select_low_n(chip_select_low_n), .sdoOe(sdoOe),
	.direct_input_a(direct_input_a), .direct_input_b(direct_input_b), .idlePin(idlePin),
	.digitalSupplyOk(digitalSupplyOk), .overload_trip_current(overload_trip_current),
	.overTemp(overTemp), .chanOn(chanOn), .idleMode(idleMode), .limpHome(limpHome)
);

// ==== bench/rdcc_spi_master.sv ====
// Purpose: Controller side of the serial link, mode 0, MSB first.
// Assumes: Paced by the system clock; one link period is eight system clocks.
// Notes:   Idle levels follow the pin pulls: clock and data low, select high.
module rdcc_spi_master (
	// Pacing clock
	input  wire logic clock,
	// Link pins
	output logic      sclk,
	output logic      sdi,
	output logic      chip_select_low_n,
	input  wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		chip_select_low_n = 1'b1;
	end
	// Low phase is longer so the reply bit has settled before it is sampled.
	task automatic xfer(input int nBits, input logic [23:0] word, output logic [23:0] rx);
		rx = '0;
		chip_select_low_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (int i = nBits - 1; i >= 0; i--) begin
			sdi <= word[i];
			repeat (5) @(posedge clock);
			rx = {rx[22:0], sdo};
			sclk <= 1'b1;
			repeat (3) @(posedge clock);
			sclk <= 1'b0;
		end
		repeat (5) @(posedge clock);
		sdi <= 1'b0;
		chip_select_low_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
endmodule

// ==== bench/rdcc_top_test.sv ====
// Purpose: Self-checking bench for the relay channel control.
// Assumes: Restart delay cut to 20 clocks; serial traffic comes from the partner model.
// Notes:   Channel states are predicted by a small behavioural model.
`include "rdcc_defs.svh"
module rdcc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RC = 20;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        inA = 1'b0;
	logic        inB = 1'b0;
	logic        idlePin = 1'b0;
	logic        supplyOk = 1'b1;
	logic [7:0]  ovl = 8'h00;
	logic [7:0]  ot = 8'h00;
	logic [7:0]  osm = 8'h00;
	logic [31:0] prdata, rdata;
	logic        pready, pslverr, rerr, sclk, sdi, chip_select_low_n, sdo, sdoOe;
	logic [7:0]  chanOn, probe, lat;
	logic        idleMode, limpHome, irq;
	logic [23:0] rx;
	int          seed = 32'h0f51;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          ctrl = 0;
	int          mapA = `RDCC_RST_MAPA;
	int          mapB = `RDCC_RST_MAPB;
	always #25 clock = ~clock;
	rdcc_top #(.RESTART_CYCLES(RC)) uut (
		.clock(clock), .rst_n(rst_n), .en(en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .sdi(sdi), .chip_select_low_n(chip_select_low_n),
		.sdo(sdo), .sdoOe(sdoOe), .direct_input_a(inA), .direct_input_b(inB),
		.idlePin(idlePin), .digitalSupplyOk(supplyOk), .overload_trip_current(ovl),
		.overTemp(ot), .output_status_monitor_bits(osm), .chanOn(chanOn),
		.open_load_probe_current(probe), .idleMode(idleMode), .limpHome(limpHome), .irq(irq));
	rdcc_spi_master link (.clock(clock), .sclk(sclk), .sdi(sdi),
	// A released data line reads as the inverse, so a late output enable spoils the reply.
		.chip_select_low_n(chip_select_low_n), .sdo(sdoOe ? sdo : ~sdo));
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Held until ready is seen at an edge; one idle cycle keeps strobes single per step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
		if (n >= 16) begin
			miscompares++;
			$display("[FAIL] %0t bus timeout", $time);
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(rdata, e);
	endtask
	function automatic logic [7:0] expChan();
		logic [7:0] v;
		v = 8'(ctrl) | (inA ? 8'(mapA) : 8'h00) | (inB ? 8'(mapB) : 8'h00);
		if (!idlePin && !supplyOk) begin
			v = 8'(ctrl);
			v[2] = inA;
			v[3] = inB;
		end
		return v & ~lat;
	endfunction
	task automatic chkChan();
		check(32'(chanOn), 32'(expChan()));
	endtask
	initial begin
		lat = 8'h00;
		tick(6);
		rst_n <= 1'b1;
		tick(1);
		rd(`RDCC_OFF_CTRL, 32'h0000_0000);
		rd(`RDCC_OFF_MAPA, `RDCC_RST_MAPA);
		rd(`RDCC_OFF_MAPB, `RDCC_RST_MAPB);
		rd(8'h24, 32'h0000_0000);
		check(32'(rerr), 32'h0000_0001);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			if (i > 0) begin
				ctrl = $random(seed) & 8'hff;
				mapA = $random(seed) & 8'hff;
				mapB = $random(seed) & 8'hff;
				wr(`RDCC_OFF_CTRL, ctrl);
				wr(`RDCC_OFF_MAPA, mapA);
				wr(`RDCC_OFF_MAPB, mapB);
			end
			for (int j = 0; j < 4; j++) begin
				inA <= j[0];
				inB <= j[1];
				tick(6);
				chkChan();
				rd(`RDCC_OFF_CHAN, 32'(expChan()));
			end
		end
		$display("test mapping done");
		inA <= 1'b0;
		wr(`RDCC_OFF_IRQMASK, 32'h0000_0007);
		check(32'(sdoOe), 32'h0000_0000);
		link.xfer(16, 24'h00_805a, rx);
		ctrl = 8'h5a;
		rd(`RDCC_OFF_CTRL, ctrl);
		check(32'(irq), 32'h0000_0001);
		link.xfer(16, 24'h00_0000, rx);
		link.xfer(16, 24'h00_0000, rx);
		check(32'(rx[15:0]), 32'h0000_005a);
		link.xfer(24, 24'hc3_803c, rx);
		check(32'(rx[7:0]), 32'h0000_00c3);
		ctrl = 8'h3c;
		rd(`RDCC_OFF_CTRL, ctrl);
		idlePin <= 1'b1;
		supplyOk <= 1'b0;
		link.xfer(16, 24'h00_80ff, rx);
		rd(`RDCC_OFF_CTRL, ctrl);
		check(32'(idleMode), 32'h0000_0001);
		wr(`RDCC_OFF_IRQSTAT, 32'h0000_0007);
		tick(2);
		check(32'(irq), 32'h0000_0000);
		$display("test serial done");
		supplyOk <= 1'b1;
		idlePin <= 1'b0;
		ctrl = 8'hff;
		wr(`RDCC_OFF_CTRL, ctrl);
		wr(`RDCC_OFF_IRQMASK, 32'h0000_0004);
		osm <= 8'($random(seed));
		ovl[5] <= 1'b1;
		ot[1] <= 1'b1;
		tick(6);
		ovl <= 8'h00;
		ot <= 8'h00;
		lat = 8'h22;
		tick(6);
		chkChan();
		check(32'(irq), 32'h0000_0000);
		rd(`RDCC_OFF_DIAG, {8'h00, osm, 16'h0220});
		rd(`RDCC_OFF_DIAG, {8'h00, osm, 16'h0000});
		rd(`RDCC_OFF_IRQSTAT, 32'h0000_0003);
		wr(`RDCC_OFF_IRQMASK, 32'h0000_0003);
		tick(2);
		check(32'(irq), 32'h0000_0001);
		wr(`RDCC_OFF_IRQSTAT, 32'h0000_0003);
		wr(`RDCC_OFF_RESTART, 32'h0000_0022);
		lat = 8'h00;
		tick(2);
		chkChan();
		check(32'(irq), 32'h0000_0000);
		wr(`RDCC_OFF_PROBE, 32'h0000_00a5);
		tick(2);
		check(32'(probe), 32'h0000_00a5);
		rd(`RDCC_OFF_PROBE, 32'h0000_00a5);
		$display("test protection done");
		ctrl = 8'h81;
		wr(`RDCC_OFF_CTRL, ctrl);
		supplyOk <= 1'b0;
		inA <= 1'b1;
		tick(6);
		check(32'(limpHome), 32'h0000_0001);
		chkChan();
		ovl[2] <= 1'b1;
		tick(4);
		ovl <= 8'h00;
		lat = 8'h04;
		tick(2);
		chkChan();
		tick(RC - 6);
		chkChan();
		tick(16);
		lat = 8'h00;
		chkChan();
		inA <= 1'b0;
		inB <= 1'b1;
		tick(6);
		chkChan();
		inB <= 1'b0;
		tick(6);
		chkChan();
		en <= 1'b0;
		inA <= 1'b1;
		tick(6);
		check(32'(chanOn), 32'h0000_0081);
		en <= 1'b1;
		tick(6);
		chkChan();
		$display("test limp home done");
		print_verdict();
	end
endmodule
